// ---- hdl/baud_config_host.v ----
// Host controller that programs the serial unit prescaler and control registers safely
`include "csi_guard_regs.vh"
`default_nettype none

//
// Contract
// - No prescaler mode write while timer/unit runs
// - Prescaler mode written before baud enable set
// - No compare write while timer/unit runs
// - Compare written before baud enable set
// - Generated baud clock at most 8 MHz
// - Read overrun flag after DMA transfer
// - Control A fields frozen while powered
// - Control B fields frozen while powered
// - Character length frozen while powered
// - Clear power once, then reinitialise unit
module baud_config_host #(
	parameter [31:0] DEV_CLK_HZ = 32'h01E8_4800 // Device peripheral clock, 32 MHz
) (
	input  wire        pclk,      // 10 MHz system clock
	input  wire        presetn,   // Async reset, active low
	input  wire        psel,      // APB select
	input  wire        penable,   // APB enable
	input  wire        pwrite,    // APB write
	input  wire [7:0]  paddr,     // APB byte address
	input  wire [31:0] pwdata,    // APB write data
	output reg  [31:0] prdata,    // APB read data
	output wire        pready,    // APB ready, always high
	output wire        pslverr,   // APB error on unmapped address
	output reg         dev_req,   // Device access request, held until ack
	output reg         dev_we,    // Device access is a write
	output reg  [2:0]  dev_addr,  // Device register address
	output reg  [7:0]  dev_wdata, // Device write data
	input  wire        dev_ack,   // Device acknowledge (four-phase)
	input  wire [7:0]  dev_rdata, // Device read data, stable while ack high
	input  wire        watch_run, // Watch timer running
	input  wire        dma_done,  // DMA transfer complete level
	output wire        irq        // Level interrupt
);

	// Operations and sequencer states
	localparam OP_NONE  = 2'b00;
	localparam OP_PRESC = 2'b01;
	localparam OP_CFG   = 2'b10;
	localparam OP_OVR   = 2'b11;
	localparam S_IDLE   = 2'b00;
	localparam S_REQ    = 2'b01;
	localparam S_REL    = 2'b10;

	reg  [1:0]      ctrl_r;     // Power and baud enable requests
	reg  [3:0]      cfg_a_r;    // txe, rxe, dir, tms
	reg  [4:0]      cfg_b_r;    // ckp, dap, cks[2:0]
	reg  [3:0]      cfg_c_r;    // Character length
	reg  [1:0]      presc_mode_r;
	reg  [7:0]      presc_cmp_r;
	reg  [`EV_W-1:0] irq_stat_r;
	reg  [`EV_W-1:0] irq_en_r;
	reg  [1:0]      state_r;
	reg  [1:0]      op_r;
	reg  [1:0]      step_r;
	reg             powered_r;  // Power bit last written to device
	reg             baud_on_r;  // Baud enable last written to device
	reg             overrun_r;  // Overrun flag from last status read
	reg             dma_prev_r;
	reg             dma_pend_r; // DMA completion waiting for an idle host
	reg  [`EV_W-1:0] ev_set;
	reg  [2:0]      step_addr;
	reg  [7:0]      step_data;
	reg             step_we;
	reg             step_last;
	wire [2:0]      sync_lv;
	wire            ack_s;
	wire            watch_s;
	wire            dma_s;
	wire            dma_rise;
	wire            dma_go;
	wire            wr_en;
	wire            rd_en;
	wire            mapped;
	wire            cmd_wr;
	wire            busy;
	wire [8:0]      cmp_eff;
	wire [39:0]     baud_lim;
	wire [31:0]     dev_div;
	wire            too_fast;
	wire            presc_blocked;
	wire            start_presc;
	wire            start_cfg;
	wire            start_ovr;

	// Pins from outside the clock domain
	pin_sync #(
		.WIDTH    (3)
	) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({dma_done, watch_run, dev_ack}),
		.sync_out (sync_lv)
	);

	assign ack_s    = sync_lv[0];
	assign watch_s  = sync_lv[1];
	assign dma_s    = sync_lv[2];
	assign dma_rise = dma_s & ~dma_prev_r;

	// APB decode, zero wait state
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign mapped  = (paddr == `HR_CTRL) | (paddr == `HR_CFG_A) | (paddr == `HR_CFG_B) |
			(paddr == `HR_CFG_C) | (paddr == `HR_PRESC) | (paddr == `HR_CMD) |
			(paddr == `HR_STATUS) | (paddr == `HR_IRQ_STAT) | (paddr == `HR_IRQ_EN) |
			(paddr == `HR_IRQ_CLR);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign cmd_wr  = wr_en & (paddr == `HR_CMD);
	assign busy    = (state_r != S_IDLE);

	assign cmp_eff  = (presc_cmp_r == `RST_BYTE) ? `CMP_ZERO_EFF : {1'b0, presc_cmp_r};
	assign baud_lim = cmp_eff * `BAUD_LIM2;
	assign dev_div  = DEV_CLK_HZ >> presc_mode_r;
	assign too_fast = ({8'h00, dev_div} > baud_lim);

	assign presc_blocked = watch_s | powered_r | too_fast;

	assign start_presc = cmd_wr & pwdata[`CMD_PRESC] & ~busy & ~presc_blocked;
	assign start_cfg   = cmd_wr & pwdata[`CMD_CFG] & ~pwdata[`CMD_PRESC] & ~busy;
	// status read after DMA completes, held pending while busy
	assign dma_go      = ~busy & ~cmd_wr & (dma_rise | dma_pend_r);
	assign start_ovr   = dma_go |
			cmd_wr & pwdata[`CMD_OVR] & ~pwdata[`CMD_CFG] & ~pwdata[`CMD_PRESC] & ~busy;

	// Device access for the current operation step
	always @*
	begin
		step_addr = `DEV_STATUS;
		step_data = `RST_BYTE;
		step_we   = 1'b0;
		step_last = 1'b1;
		case (op_r)
			OP_PRESC:
			begin
				step_we   = 1'b1;
				step_last = (step_r == 2'd2);
				case (step_r)
					2'd0:
					begin
						step_addr = `DEV_PRESC_MODE;
						step_data = {6'h00, presc_mode_r};
					end
					2'd1:
					begin
						step_addr = `DEV_PRESC_CMP;
						step_data = presc_cmp_r;
					end
					// enable set only as the final step
					default:
					begin
						step_addr = `DEV_PRESC_MODE;
						step_data = {6'h00, presc_mode_r};
						step_data[`DM_BGCE] = ctrl_r[`CTRL_BAUD_EN];
					end
				endcase
			end
			OP_CFG:
			begin
				step_we   = 1'b1;
				step_last = (step_r == 2'd3);
				case (step_r)
					// power cleared before frozen fields change
					2'd0:
					begin
						step_addr = `DEV_CTL_A;
						step_data = `RST_BYTE;
					end
					2'd1:
					begin
						step_addr = `DEV_CTL_B;
						step_data = {3'h0, cfg_b_r};
					end
					2'd2:
					begin
						step_addr = `DEV_CTL_C;
						step_data = {4'h0, cfg_c_r};
					end
					// fields and power set together last
					default:
					begin
						step_addr = `DEV_CTL_A;
						step_data = `RST_BYTE;
						step_data[`DA_TXE] = cfg_a_r[3];
						step_data[`DA_RXE] = cfg_a_r[2];
						step_data[`DA_DIR] = cfg_a_r[1];
						step_data[`DA_TMS] = cfg_a_r[0];
						step_data[`DA_PWR] = ctrl_r[`CTRL_PWR];
					end
				endcase
			end
			OP_OVR:
			begin
				step_addr = `DEV_STATUS;
				step_we   = 1'b0;
				step_last = 1'b1;
			end
			default:
			begin
				step_last = 1'b1;
			end
		endcase
	end

	// Sequencer and device port, four-phase handshake
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r   <= S_IDLE;
			op_r      <= OP_NONE;
			step_r    <= 2'd0;
			dev_req   <= 1'b0;
			dev_we    <= 1'b0;
			dev_addr  <= `DEV_STATUS;
			dev_wdata <= `RST_BYTE;
			powered_r <= 1'b0;
			baud_on_r <= 1'b0;
			overrun_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				S_IDLE:
				begin
					if (start_presc | start_cfg | start_ovr)
					begin
						op_r    <= start_presc ? OP_PRESC : (start_cfg ? OP_CFG : OP_OVR);
						step_r  <= 2'd0;
						state_r <= S_REQ;
					end
				end
				S_REQ:
				begin
					dev_req   <= 1'b1;
					dev_we    <= step_we;
					dev_addr  <= step_addr;
					dev_wdata <= step_data;
					if (dev_req & ack_s)
					begin
						dev_req <= 1'b0;
						state_r <= S_REL;
						if (step_we & (step_addr == `DEV_CTL_A))
						begin
							powered_r <= step_data[`DA_PWR];
						end
						if (step_we & (step_addr == `DEV_PRESC_MODE))
						begin
							baud_on_r <= step_data[`DM_BGCE];
						end
						if (~step_we)
						begin
							overrun_r <= dev_rdata[`DS_OVE];
						end
					end
				end
				S_REL:
				begin
					if (~ack_s)
					begin
						if (step_last)
						begin
							state_r <= S_IDLE;
							op_r    <= OP_NONE;
						end
						else
						begin
							step_r  <= step_r + 2'd1;
							state_r <= S_REQ;
						end
					end
				end
				default:
				begin
					state_r <= S_IDLE;
				end
			endcase
		end
	end

	// Event pulses for the interrupt status
	always @*
	begin
		ev_set = {`EV_W{1'b0}};
		ev_set[`EV_DONE]     = (state_r == S_REL) & ~ack_s & step_last;
		ev_set[`EV_REFUSED]  = cmd_wr & (busy | (pwdata[`CMD_PRESC] & presc_blocked));
		ev_set[`EV_OVERRUN]  = (state_r == S_REQ) & dev_req & ack_s & ~step_we &
				dev_rdata[`DS_OVE];
		ev_set[`EV_TOO_FAST] = cmd_wr & pwdata[`CMD_PRESC] & too_fast;
	end

	// Host registers written over APB
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_r       <= 2'b00;
			cfg_a_r      <= 4'h0;
			cfg_b_r      <= 5'h00;
			cfg_c_r      <= 4'h0;
			presc_mode_r <= 2'b00;
			presc_cmp_r  <= `RST_BYTE;
			irq_en_r     <= {`EV_W{1'b0}};
			irq_stat_r   <= {`EV_W{1'b0}};
			dma_prev_r   <= 1'b0;
			dma_pend_r   <= 1'b0;
		end
		else
		begin
			dma_prev_r <= dma_s;
			// A completion seen while busy is not lost
			dma_pend_r <= ~dma_go & (dma_pend_r | dma_rise);
			if (wr_en & (paddr == `HR_CTRL))
			begin
				ctrl_r <= pwdata[1:0];
			end
			if (wr_en & (paddr == `HR_CFG_A))
			begin
				cfg_a_r <= pwdata[3:0];
			end
			if (wr_en & (paddr == `HR_CFG_B))
			begin
				cfg_b_r <= pwdata[4:0];
			end
			if (wr_en & (paddr == `HR_CFG_C))
			begin
				cfg_c_r <= pwdata[3:0];
			end
			if (wr_en & (paddr == `HR_PRESC))
			begin
				presc_mode_r <= pwdata[1:0];
				presc_cmp_r  <= pwdata[15:8];
			end
			if (wr_en & (paddr == `HR_IRQ_EN))
			begin
				irq_en_r <= pwdata[`EV_W-1:0];
			end
			// Set wins over clear
			if (wr_en & (paddr == `HR_IRQ_CLR))
			begin
				irq_stat_r <= (irq_stat_r & ~pwdata[`EV_W-1:0]) | ev_set;
			end
			else
			begin
				irq_stat_r <= irq_stat_r | ev_set;
			end
		end
	end

	// APB read data, registered on the setup phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= `RST_WORD;
		end
		else if (psel & ~penable & ~pwrite)
		begin
			prdata <= `RST_WORD;
			case (paddr)
				`HR_CTRL:     prdata[1:0]  <= ctrl_r;
				`HR_CFG_A:    prdata[3:0]  <= cfg_a_r;
				`HR_CFG_B:    prdata[4:0]  <= cfg_b_r;
				`HR_CFG_C:    prdata[3:0]  <= cfg_c_r;
				`HR_PRESC:    prdata[15:0] <= {presc_cmp_r, 6'h00, presc_mode_r};
				`HR_STATUS:
				begin
					prdata[`ST_BUSY]    <= busy;
					prdata[`ST_POWERED] <= powered_r;
					prdata[`ST_BAUD_ON] <= baud_on_r;
					prdata[`ST_OVERRUN] <= overrun_r;
					prdata[`ST_WATCH]   <= watch_s;
				end
				`HR_IRQ_STAT: prdata[`EV_W-1:0] <= irq_stat_r;
				`HR_IRQ_EN:   prdata[`EV_W-1:0] <= irq_en_r;
				default:      prdata <= `RST_WORD;
			endcase
		end
	end

	// Level interrupt from enabled sticky bits
	assign irq = |(irq_stat_r & irq_en_r);

endmodule

`default_nettype wire

// ---- hdl/csi_guard_regs.vh ----
// Register offsets, field positions and limits for the baud and config guard host
`ifndef CSI_GUARD_REGS_VH
`define CSI_GUARD_REGS_VH

// APB register byte offsets of the host
`define HR_CTRL        8'h00
`define HR_CFG_A       8'h04
`define HR_CFG_B       8'h08
`define HR_CFG_C       8'h0C
`define HR_PRESC       8'h10
`define HR_CMD         8'h14
`define HR_STATUS      8'h18
`define HR_IRQ_STAT    8'h1C
`define HR_IRQ_EN      8'h20
`define HR_IRQ_CLR     8'h24

// Host CTRL fields
`define CTRL_PWR       0
`define CTRL_BAUD_EN   1

// Host CMD fields
`define CMD_PRESC      0
`define CMD_CFG        1
`define CMD_OVR        2

// Host STATUS fields
`define ST_BUSY        0
`define ST_POWERED     1
`define ST_BAUD_ON     2
`define ST_OVERRUN     3
`define ST_WATCH       4

// Interrupt event bits
`define EV_DONE        0
`define EV_REFUSED     1
`define EV_OVERRUN     2
`define EV_TOO_FAST    3
`define EV_W           4

// Device register addresses on the device port
`define DEV_PRESC_MODE 3'h0
`define DEV_PRESC_CMP  3'h1
`define DEV_CTL_A      3'h2
`define DEV_CTL_B      3'h3
`define DEV_CTL_C      3'h4
`define DEV_STATUS     3'h5

// Device field positions
`define DA_PWR         7
`define DA_TXE         6
`define DA_RXE         5
`define DA_DIR         4
`define DA_TMS         1
`define DM_BGCE        4
`define DS_OVE         0

// Baud ceiling times two, in Hz (2 x 8 MHz)
`define BAUD_LIM2      40'h00_00F4_2400
// Compare value used when the compare field is zero
`define CMP_ZERO_EFF   9'h100

// Reset values
`define RST_BYTE       8'h00
`define RST_WORD       32'h0000_0000

`endif

// ---- hdl/pin_sync.v ----
// Two-flop synchroniser for a group of asynchronous input pins
`default_nettype none

module pin_sync #(
	parameter WIDTH = 3
) (
	input  wire             pclk,    // System clock
	input  wire             presetn, // Async reset, active low
	input  wire [WIDTH-1:0] async_in, // Raw pins
	output wire [WIDTH-1:0] sync_out  // Synchronised levels
);

	genvar gi;

	// One two-flop chain per pin
	generate
		for (gi = 0; gi < WIDTH; gi = gi + 1)
		begin : g_bit
			reg meta_r;
			reg stable_r;
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					meta_r   <= 1'b0;
					stable_r <= 1'b0;
				end
				else
				begin
					meta_r   <= async_in[gi];
					stable_r <= meta_r;
				end
			end
			assign sync_out[gi] = stable_r;
		end
	endgenerate

endmodule

`default_nettype wire

// ---- verification/baud_config_host_asserts.sv ----
// Concurrent checks on the device port of the baud and config guard host
`include "csi_guard_regs.vh"
`default_nettype none

module baud_config_host_asserts #(
	parameter [31:0] DEV_CLK_HZ = 32'h01E8_4800 // Device peripheral clock
) (
	input wire logic       pclk,      // System clock
	input wire logic       presetn,   // Reset, active low
	input wire logic       dev_req,   // Device request
	input wire logic       dev_we,    // Device write
	input wire logic [2:0] dev_addr,  // Device address
	input wire logic [7:0] dev_wdata, // Device write data
	input wire logic       watch_run, // Watch timer running
	input wire logic       dma_done   // DMA complete level
);
	timeunit 1ns;
	timeprecision 1ns;
	logic       req_d;
	logic       pwr_r;
	logic       cmp_ok_r;
	logic [8:0] cmp_r;
	logic       st;

	// Start of a device write
	assign st = dev_req && !req_d && dev_we;

	// Device state as seen from the writes
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			req_d <= 1'h0;
			pwr_r <= 1'h0;
			cmp_ok_r <= 1'h0;
			cmp_r <= 9'h100;
		end
		else
		begin
			req_d <= dev_req;
			if (st && dev_addr == 3'h2)
				pwr_r <= dev_wdata[7];
			if (st && dev_addr == 3'h1)
				cmp_r <= (dev_wdata == 8'h00) ? 9'h100 : {1'h0, dev_wdata};
			if (st && dev_addr == 3'h1)
				cmp_ok_r <= 1'h1;
			if (st && dev_addr == 3'h0 && !dev_wdata[4])
				cmp_ok_r <= 1'h0;
		end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_mode_idle;
		st && dev_addr == 3'h0 |-> !watch_run && !pwr_r;
	endproperty
	a_mode_idle: assert property (p_mode_idle) else $error("mode write while running");

	property p_cmp_idle;
		st && dev_addr == 3'h1 |-> !watch_run && !pwr_r;
	endproperty
	a_cmp_idle: assert property (p_cmp_idle) else $error("compare write while running");

	property p_cmp_first;
		st && dev_addr == 3'h0 && dev_wdata[4] |-> cmp_ok_r;
	endproperty
	a_cmp_first: assert property (p_cmp_first) else $error("enable before compare");

	property p_ceiling;
		st && dev_addr == 3'h0 && dev_wdata[4] |->
			(DEV_CLK_HZ >> dev_wdata[1:0]) <= `BAUD_LIM2 * cmp_r;
	endproperty
	a_ceiling: assert property (p_ceiling) else $error("baud clock too fast");

	property p_ovr_read;
		$rose(dma_done) |-> ##[1:12] (dev_req && !dev_we && dev_addr == 3'h5);
	endproperty
	a_ovr_read: assert property (p_ovr_read) else $error("no status read after DMA");

	property p_ctla;
		st && dev_addr == 3'h2 && pwr_r |-> !dev_wdata[7];
	endproperty
	a_ctla: assert property (p_ctla) else $error("control a rewritten while powered");

	property p_ctlb;
		st && dev_addr == 3'h3 |-> !pwr_r;
	endproperty
	a_ctlb: assert property (p_ctlb) else $error("control b rewritten while powered");

	property p_ctlc;
		st && dev_addr == 3'h4 |-> !pwr_r;
	endproperty
	a_ctlc: assert property (p_ctlc) else $error("length rewritten while powered");

	property p_reinit;
		st && dev_addr == 3'h2 && dev_wdata[7] |-> !pwr_r;
	endproperty
	a_reinit: assert property (p_reinit) else $error("power set without clearing");
endmodule

bind baud_config_host baud_config_host_asserts #(.DEV_CLK_HZ(DEV_CLK_HZ)) chk (
	.pclk(pclk),
	.presetn(presetn),
	.dev_req(dev_req),
	.dev_we(dev_we),
	.dev_addr(dev_addr),
	.dev_wdata(dev_wdata),
	.watch_run(watch_run),
	.dma_done(dma_done)
);

`default_nettype wire

// ---- verification/serial_dev_model.sv ----
// Behavioural serial unit with prescaler, control and status registers
`default_nettype none

module serial_dev_model (
	input  wire logic       pclk,      // System clock
	input  wire logic       presetn,   // Reset, active low
	input  wire logic       dev_req,   // Request from host
	input  wire logic       dev_we,    // Write request
	input  wire logic [2:0] dev_addr,  // Register address
	input  wire logic [7:0] dev_wdata, // Write data
	input  wire logic       slow,      // Stretch the handshake
	input  wire logic       ovr_in,    // Overrun during transfer
	output var  logic       dev_ack,   // Acknowledge
	output wire logic [7:0] dev_rdata  // Read data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] regs [0:5];
	int         n;

	// Released read lines show the inverse of the register
	assign dev_rdata = dev_ack ? regs[dev_addr] : ~regs[dev_addr];

	// Four-phase answer, delayed when slow
	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			dev_ack <= 1'h0;
			n <= 0;
			regs <= '{default: 8'h00};
		end
		else
		begin
			if (ovr_in && regs[2][7])
				regs[5][0] <= 1'h1;
			if (dev_req != dev_ack && n < (slow ? 4 : 0))
				n <= n + 1;
			else if (dev_req != dev_ack)
			begin
				n <= 0;
				dev_ack <= dev_req;
				if (dev_req && dev_we)
					regs[dev_addr] <= dev_wdata;
				if (dev_req && dev_we && dev_addr == 3'h2 && !dev_wdata[7])
					regs[5] <= 8'h00;
			end
		end
endmodule

`default_nettype wire

// ---- verification/csi_baud_and_config_guard_test.sv ----
// Self-checking bench for the baud and config guard host
`include "csi_guard_regs.vh"
`default_nettype none

module csi_baud_and_config_guard_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr, dev_wdata, dev_rdata;
	logic [31:0] pwdata, prdata, rd;
	logic        dev_req, dev_we, dev_ack, watch_run, dma_done, irq, slow, ovr, er;
	logic [2:0]  dev_addr;
	int          fail_count = 0;
	int          cmp_count = 0;
	// Rows: ctrl, events, mode byte, compare byte, prescaler word
	logic [39:0] rows [0:3] = '{40'h21_1002_0200, 40'h21_1101_0101,
		40'h2A_1101_0100, 40'h01_0300_0003};

	baud_config_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dev_req(dev_req), .dev_we(dev_we), .dev_addr(dev_addr),
		.dev_wdata(dev_wdata), .dev_ack(dev_ack), .dev_rdata(dev_rdata),
		.watch_run(watch_run), .dma_done(dma_done), .irq(irq));

	serial_dev_model m (.pclk(pclk), .presetn(presetn), .dev_req(dev_req), .dev_we(dev_we),
		.dev_addr(dev_addr), .dev_wdata(dev_wdata), .slow(slow), .ovr_in(ovr),
		.dev_ack(dev_ack), .dev_rdata(dev_rdata));

	// Clock
	always #50 pclk = ~pclk;

	// Compare and report
	task chk(input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e)
		begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// One APB transfer
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Wait until the host is idle
	task wt;
		repeat (4) @(posedge pclk);
		rd = 32'h0000_0001;
		for (int k = 0; k < 200 && rd[0] !== 1'h0; k++)
			bus(1'h0, `HR_STATUS, 32'h0000_0000);
	endtask

	// Final verdict
	task give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (20000) @(posedge pclk);
		fail_count++;
		give_verdict;
	end

	// Main sequence
	initial
	begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{watch_run, dma_done, slow, ovr} = '0;
		repeat (4) @(posedge pclk);
		chk(dev_req, 1'h0);
		chk(dev_addr, 3'h5);
		presetn <= 1'h1;
		bus(1'h0, `HR_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		bus(1'h0, 8'h40, 32'h0000_0000);
		chk(er, 1'h1);
		chk(rd, 32'h0000_0000);
		$display("reset and unmapped done");
		for (int i = 0; i < 4; i++)
		begin
			slow <= i[0];
			bus(1'h1, `HR_PRESC, {16'h0000, rows[i][15:0]});
			bus(1'h1, `HR_CTRL, {28'h000_0000, rows[i][39:36]});
			bus(1'h1, `HR_CMD, 32'h0000_0001);
			wt();
			bus(1'h0, `HR_IRQ_STAT, 32'h0000_0000);
			chk(rd[3:0], rows[i][35:32]);
			chk(m.regs[0], rows[i][31:24]);
			chk(m.regs[1], rows[i][23:16]);
			bus(1'h1, `HR_IRQ_CLR, 32'h0000_000F);
		end
		$display("prescaler rows done");
		bus(1'h1, `HR_CFG_A, 32'h0000_000F);
		bus(1'h1, `HR_CFG_B, 32'h0000_0015);
		bus(1'h1, `HR_CFG_C, 32'h0000_000A);
		bus(1'h1, `HR_CTRL, 32'h0000_0001);
		bus(1'h1, `HR_CMD, 32'h0000_0002);
		wt();
		chk(m.regs[2], 8'hF2);
		chk(m.regs[3], 8'h15);
		chk(m.regs[4], 8'h0A);
		chk(rd[2:1], 2'b01);
		bus(1'h1, `HR_CMD, 32'h0000_0001);
		wt();
		bus(1'h0, `HR_IRQ_STAT, 32'h0000_0000);
		chk(rd[1], 1'h1);
		bus(1'h1, `HR_CFG_A, 32'h0000_0000);
		bus(1'h1, `HR_CMD, 32'h0000_0002);
		wt();
		chk(m.regs[2], 8'h80);
		$display("powered config done");
		ovr <= 1'h1;
		bus(1'h1, `HR_IRQ_EN, 32'h0000_0004);
		ovr <= 1'h0;
		dma_done <= 1'h1;
		wt();
		bus(1'h0, `HR_STATUS, 32'h0000_0000);
		chk(rd[3], 1'h1);
		@(negedge pclk);
		chk(irq, 1'h1);
		bus(1'h1, `HR_IRQ_EN, 32'h0000_0000);
		@(negedge pclk);
		chk(irq, 1'h0);
		bus(1'h1, `HR_IRQ_EN, 32'h0000_0004);
		bus(1'h1, `HR_IRQ_CLR, 32'h0000_000F);
		@(negedge pclk);
		chk(irq, 1'h0);
		$display("overrun and interrupt done");
		bus(1'h1, `HR_CTRL, 32'h0000_0000);
		bus(1'h1, `HR_CMD, 32'h0000_0002);
		wt();
		watch_run <= 1'h1;
		repeat (4) @(posedge pclk);
		bus(1'h1, `HR_CMD, 32'h0000_0001);
		wt();
		chk(rd[4], 1'h1);
		bus(1'h0, `HR_IRQ_STAT, 32'h0000_0000);
		chk(rd[1], 1'h1);
		watch_run <= 1'h0;
		$display("watch timer done");
		give_verdict;
	end
endmodule

`default_nettype wire
